// ===== hw/irq_ctrl_unit.sv
// Purpose: One vectoring interrupt controller with a programmable vector base.
// Assumes: Requests are level sensitive and already synchronised.
// Notes: Input 0 has the highest priority.
`timescale 1ns/100ps
module irq_ctrl_unit
  import irq_pkg::*;
#(
  parameter int INPUTS = CTRL_INPUTS
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [INPUTS-1:0] req_i,
  input wire logic base_wr_i,
  input wire logic [VEC_BASE_W-1:0] base_i,
  output logic int_o,
  output logic [VEC_W-1:0] vector_o,
  output logic [INPUTS-1:0] pending_o
);

  logic [VEC_BASE_W-1:0] base_reg;
  logic [VEC_IDX_W-1:0] idx;
  logic [INPUTS-1:0] lower_mask;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  // The vector base is loaded by a write at this controller's address.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      base_reg <= VEC_BASE_RST;
    end else if (base_wr_i) begin
      base_reg <= base_i;
    end
  end

  // Scan downward so the lowest active input is the one that sticks.
  always_comb begin
    idx = '0;
    for (int i = INPUTS - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        idx = VEC_IDX_W'(i);
      end
    end
  end

  assign int_o = |req_i;
  assign vector_o = {base_reg, idx};
  assign pending_o = req_i;
  assign lower_mask = (INPUTS'(1) << idx) - INPUTS'(1);

  base_load_a: assert property (
    base_wr_i |=> vector_o[VEC_W-1:VEC_IDX_W] == $past(base_i))
    else $error("vector base not loaded by controller write");

  vector_index_a: assert property (
    int_o |-> req_i[vector_o[VEC_IDX_W-1:0]] && (req_i & lower_mask) == '0)
    else $error("vector index is not the highest active input");

endmodule

// ===== hw/irq_pkg.sv
// Purpose: Shared constants for interrupt vectoring, level 7 and parity logic.
// Assumes: A 24-bit logical address and a 32-bit memory data path.
// Notes: The cycle-by-cycle contract is given with the top-level module.
// Behaviour
// - Acknowledge cycle returns the interrupting source's vector.
// - Address bits 19..13 select MMU, FPU, vectors.
// - Two cascaded controllers at 009400 and 009500.
// - Vector: base in bits 7..3, input 2..0.
// - Other interrupts go through the two controllers.
// - Parity error raises non-maskable level 7.
// - Level 7 acknowledge requests autovectoring.
// - Level 7 from RAM parity or channel check.
// - Status shows which source raised level 7.
// - A status write clears latched level 7 status unless its source is active in that cycle.
// - Memory word is 32 data plus 4 parity.
// - Generate parity on writes, check on reads.
// - Diagnostic mode forces wrong parity into storage.
package irq_pkg;

  // Logical bus layout.
  localparam int ADDR_W = 24;
  localparam int CPU_TYPE_HI = 19;
  localparam int CPU_TYPE_LO = 16;
  localparam int CPID_HI = 15;
  localparam int CPID_LO = 13;
  localparam int IACK_LVL_HI = 3;
  localparam int IACK_LVL_LO = 1;
  localparam logic [2:0] FC_CPU_SPACE = 3'h7;
  localparam logic [3:0] CPU_TYPE_MMU = 4'h1;
  localparam logic [3:0] CPU_TYPE_COPRO = 4'h2;
  localparam logic [3:0] CPU_TYPE_IACK = 4'hf;
  localparam logic [2:0] FPU_CPID = 3'h1;

  // Controller addresses and vector byte layout.
  localparam logic [ADDR_W-1:0] CTRL1_ADDR = 24'h00_9400;
  localparam logic [ADDR_W-1:0] CTRL2_ADDR = 24'h00_9500;
  localparam int CTRL_INPUTS = 8;
  localparam int REQ_LINES = 2 * CTRL_INPUTS;
  localparam int VEC_W = 8;
  localparam int VEC_IDX_W = 3;
  localparam int VEC_BASE_W = VEC_W - VEC_IDX_W;
  localparam logic [VEC_BASE_W-1:0] VEC_BASE_RST = 5'h00;
  localparam logic [VEC_IDX_W-1:0] CASCADE_INPUT = 3'h2;

  // Priority levels; the autovector entry is what the processor fetches.
  localparam logic [2:0] NMI_LEVEL = 3'h7;
  localparam logic [2:0] IPL_NONE = 3'h0;
  localparam logic [2:0] CTRL_LEVEL_DEF = 3'h4;
  localparam logic [7:0] AUTOVEC_OFFSET = 8'h7c;

  // Pin synchroniser idle value: channel check high, requests low.
  localparam logic [REQ_LINES:0] PIN_IDLE = 17'h1_0000;

  // Memory word: data plus one parity bit per byte.
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int PAR_W = DATA_W / BYTE_W;
  localparam int MEM_W = DATA_W + PAR_W;
  localparam int MEM_AW_DEF = 8;
  localparam logic PARITY_ODD = 1'b1;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

  // Odd parity per byte: the stored bit makes each nine-bit group odd.
  function automatic logic [PAR_W-1:0] byte_parity(input logic [DATA_W-1:0] d);
    logic [PAR_W-1:0] p;
    p = '0;
    for (int b = 0; b < PAR_W; b++) begin
      p[b] = ^d[b*BYTE_W +: BYTE_W] ^ PARITY_ODD;
    end
    return p;
  endfunction

endpackage

// ===== hw/irq_vector_parity_nmi.sv
// Purpose: Interrupt vectoring, level 7 parity/channel-check interrupt, parity RAM.
// Assumes: Processor bus on clock_i; request and channel-check lines are pins.
// Notes: Answers come one cycle after the strobe falls and hold until it rises.
`timescale 1ns/100ps
module irq_vector_parity_nmi
  import irq_pkg::*;
#(
  parameter logic [2:0] CTRL_LEVEL = CTRL_LEVEL_DEF,
  parameter int MEM_AW = MEM_AW_DEF
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic as_b_i,
  input wire logic rw_i,
  input wire logic [2:0] fc_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [VEC_W-1:0] data_i,
  output logic [VEC_W-1:0] data_o,
  output logic dsack_o,
  output logic autovec_o,
  output logic berr_o,
  output logic mmu_sel_o,
  output logic fpu_sel_o,
  output logic [2:0] ipl_o,
  input wire logic [REQ_LINES-1:0] request_i,
  input wire logic io_channel_check_n_i,
  input wire logic status_write_i,
  output logic ram_parity_flag_o,
  output logic io_check_flag_o,
  input wire logic diag_bad_parity_i,
  input wire logic [MEM_AW-1:0] mem_addr_i,
  input wire logic mem_wr_i,
  input wire logic mem_rd_i,
  input wire logic [DATA_W-1:0] mem_wdata_i,
  output logic [DATA_W-1:0] mem_rdata_o,
  output logic mem_rvalid_o,
  output logic parity_error_o
);

  typedef enum logic [1:0] {
    RESP_NONE,
    RESP_DSACK,
    RESP_AUTO,
    RESP_BERR
  } resp_t;

  logic [REQ_LINES:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_stable_reg;
  logic [REQ_LINES-1:0] req_stable;
  logic io_chk_act;
  logic as_act, as_seen_reg, cyc_start;
  logic cpu_space, is_iack, ctrl1_hit, ctrl2_hit;
  logic [3:0] sp_type;
  logic [2:0] cpid, iack_level;
  logic [CTRL_INPUTS-1:0] c1_req, c1_pend, c2_pend;
  logic c1_int, c2_int;
  logic [VEC_W-1:0] c1_vec, c2_vec, sel_vec;
  resp_t resp_reg, resp_next;
  logic [VEC_W-1:0] data_reg, data_next;
  logic ram_flag_reg, io_flag_reg, nmi;
  logic [MEM_W-1:0] mem_array [2**MEM_AW];
  logic [MEM_W-1:0] rd_word;
  logic [PAR_W-1:0] wr_par;
  logic rd_bad;
  logic [DATA_W-1:0] rdata_reg;
  logic rvalid_reg, perr_reg;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  // Three-stage pin synchroniser; stage one feeds only stage two.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_s1_reg <= PIN_IDLE;
      pin_s2_reg <= PIN_IDLE;
      pin_s3_reg <= PIN_IDLE;
    end else begin
      pin_s1_reg <= {io_channel_check_n_i, request_i};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // A pin change counts only once stages two and three agree.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_stable_reg <= PIN_IDLE;
    end else begin
      pin_stable_reg <= (pin_s2_reg & pin_s3_reg)
                      | (pin_stable_reg & (pin_s2_reg ^ pin_s3_reg));
    end
  end

  assign req_stable = pin_stable_reg[REQ_LINES-1:0];
  assign io_chk_act = !pin_stable_reg[REQ_LINES];

  // CPU-space decode from the type and coprocessor-id fields.
  assign as_act = !as_b_i;
  assign cyc_start = as_act && !as_seen_reg;
  assign cpu_space = fc_i == FC_CPU_SPACE;
  assign sp_type = addr_i[CPU_TYPE_HI:CPU_TYPE_LO];
  assign cpid = addr_i[CPID_HI:CPID_LO];
  assign iack_level = addr_i[IACK_LVL_HI:IACK_LVL_LO];
  assign is_iack = as_act && cpu_space && sp_type == CPU_TYPE_IACK;
  assign mmu_sel_o = as_act && cpu_space && sp_type == CPU_TYPE_MMU;
  assign fpu_sel_o = as_act && cpu_space && sp_type == CPU_TYPE_COPRO
                     && cpid == FPU_CPID;
  assign ctrl1_hit = as_act && !cpu_space && addr_i == CTRL1_ADDR;
  assign ctrl2_hit = as_act && !cpu_space && addr_i == CTRL2_ADDR;

  // Second controller shares the cascade input of the first, wire-OR style.
  always_comb begin
    c1_req = req_stable[CTRL_INPUTS-1:0];
    c1_req[CASCADE_INPUT] = req_stable[CASCADE_INPUT] | c2_int;
  end

  irq_ctrl_unit #(
    .INPUTS(CTRL_INPUTS)
  ) ctrl1_u (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .req_i(c1_req),
    .base_wr_i(cyc_start && ctrl1_hit && !rw_i),
    .base_i(data_i[VEC_W-1:VEC_IDX_W]),
    .int_o(c1_int),
    .vector_o(c1_vec),
    .pending_o(c1_pend)
  );

  irq_ctrl_unit #(
    .INPUTS(CTRL_INPUTS)
  ) ctrl2_u (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .req_i(req_stable[REQ_LINES-1:CTRL_INPUTS]),
    .base_wr_i(cyc_start && ctrl2_hit && !rw_i),
    .base_i(data_i[VEC_W-1:VEC_IDX_W]),
    .int_o(c2_int),
    .vector_o(c2_vec),
    .pending_o(c2_pend)
  );

  // A cascade hit hands the vector over to the second controller.
  assign sel_vec = (c1_vec[VEC_IDX_W-1:0] == CASCADE_INPUT && c2_int)
                   ? c2_vec : c1_vec;

  // Priority level: level 7 always masks controller requests.
  always_comb begin
    if (nmi) begin
      ipl_o = NMI_LEVEL;
    end else if (c1_int) begin
      ipl_o = CTRL_LEVEL;
    end else begin
      ipl_o = IPL_NONE;
    end
  end

  // Answer chosen at the strobe's first cycle; unclaimed acknowledges get
  // a bus error so the processor never hangs on a spurious level.
  always_comb begin
    resp_next = RESP_NONE;
    data_next = data_reg;
    if (is_iack) begin
      if (iack_level == NMI_LEVEL && nmi) begin
        resp_next = RESP_AUTO;
      end else if (iack_level == CTRL_LEVEL && c1_int) begin
        resp_next = RESP_DSACK;
        data_next = sel_vec;
      end else begin
        resp_next = RESP_BERR;
      end
    end else if (ctrl1_hit) begin
      resp_next = RESP_DSACK;
      data_next = rw_i ? c1_pend : data_reg;
    end else if (ctrl2_hit) begin
      resp_next = RESP_DSACK;
      data_next = rw_i ? c2_pend : data_reg;
    end
  end

  // Strobe edge tracker.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      as_seen_reg <= 1'b0;
    end else begin
      as_seen_reg <= as_act;
    end
  end

  // Answer state holds until the strobe is released.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      resp_reg <= RESP_NONE;
    end else if (!as_act) begin
      resp_reg <= RESP_NONE;
    end else if (cyc_start) begin
      resp_reg <= resp_next;
    end
  end

  // Read data is captured once per cycle so it is stable under the strobe.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_reg <= '0;
    end else if (cyc_start) begin
      data_reg <= data_next;
    end
  end

  assign data_o = data_reg;
  always_comb begin
    dsack_o = 1'b0;
    autovec_o = 1'b0;
    berr_o = 1'b0;
    case (resp_reg)
      RESP_NONE: dsack_o = 1'b0;
      RESP_DSACK: dsack_o = 1'b1;
      RESP_AUTO: autovec_o = 1'b1;
      RESP_BERR: berr_o = 1'b1;
      default: dsack_o = 1'b0;
    endcase
  end

  // Parity array: storage has no reset, so read only written words.
  assign wr_par = byte_parity(mem_wdata_i) ^ {PAR_W{diag_bad_parity_i}};
  always_ff @(posedge clock_i) begin
    if (mem_wr_i) begin
      mem_array[mem_addr_i] <= {wr_par, mem_wdata_i};
    end
  end

  // Check happens on the array output so the flag lines up with the data.
  assign rd_word = mem_array[mem_addr_i];
  assign rd_bad = mem_rd_i
    && byte_parity(rd_word[DATA_W-1:0]) != rd_word[MEM_W-1:DATA_W];

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_reg <= DATA_RST;
      rvalid_reg <= 1'b0;
      perr_reg <= 1'b0;
    end else begin
      rvalid_reg <= mem_rd_i;
      perr_reg <= rd_bad;
      if (mem_rd_i) begin
        rdata_reg <= rd_word[DATA_W-1:0];
      end
    end
  end

  assign mem_rdata_o = rdata_reg;
  assign mem_rvalid_o = rvalid_reg;
  assign parity_error_o = perr_reg;

  // Sticky sources; a new event in the clearing cycle wins over the clear.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ram_flag_reg <= 1'b0;
      io_flag_reg <= 1'b0;
    end else begin
      ram_flag_reg <= rd_bad || (ram_flag_reg && !status_write_i);
      io_flag_reg <= io_chk_act || (io_flag_reg && !status_write_i);
    end
  end

  assign nmi = ram_flag_reg || io_flag_reg;
  assign ram_parity_flag_o = ram_flag_reg;
  assign io_check_flag_o = io_flag_reg;

  sequence ctrl_ack_s;
    cyc_start && is_iack && iack_level == CTRL_LEVEL && c1_int;
  endsequence

  sequence nmi_ack_s;
    cyc_start && is_iack && iack_level == NMI_LEVEL && nmi;
  endsequence

  sequence clean_wr_s;
    mem_wr_i && !diag_bad_parity_i;
  endsequence

  sequence bad_wr_s;
    mem_wr_i && diag_bad_parity_i;
  endsequence

  sequence reread_s;
    mem_rd_i && !mem_wr_i && mem_addr_i == $past(mem_addr_i);
  endsequence

  iack_vector_a: assert property (
    ctrl_ack_s |=> dsack_o && !autovec_o && data_o == $past(sel_vec))
    else $error("acknowledge did not return the controller vector");

  cpu_decode_a: assert property (
    is_iack |-> !mmu_sel_o && !fpu_sel_o)
    else $error("acknowledge cycle also selected another device");

  ctrl_read_a: assert property (
    cyc_start && ctrl2_hit && rw_i |=> dsack_o && data_o == $past(c2_pend))
    else $error("second controller did not answer at its address");

  ctrl_level_a: assert property (
    !nmi && c1_int |-> ipl_o == CTRL_LEVEL)
    else $error("controller request not presented at its level");

  nmi_level_a: assert property (
    rd_bad |=> ipl_o == NMI_LEVEL && ram_parity_flag_o)
    else $error("parity error did not raise level 7");

  autovec_ack_a: assert property (
    nmi_ack_s |=> autovec_o && !dsack_o && !berr_o)
    else $error("level 7 acknowledge did not autovector");

  chk_source_a: assert property (
    io_chk_act |=> io_check_flag_o && ipl_o == NMI_LEVEL)
    else $error("channel check did not raise level 7");

  source_split_a: assert property (
    !io_chk_act && !io_flag_reg && rd_bad |=> !io_check_flag_o)
    else $error("parity error reported as channel check");

  status_clear_a: assert property (
    status_write_i && !rd_bad && !io_chk_act |=> !nmi && ipl_o != NMI_LEVEL)
    else $error("status write did not clear level 7");

  parity_good_a: assert property (
    clean_wr_s ##1 reread_s |=> !parity_error_o
      && mem_rdata_o == $past(mem_wdata_i, 2))
    else $error("clean write read back with parity error");

  forced_bad_a: assert property (
    bad_wr_s ##1 reread_s |=> parity_error_o && mem_rvalid_o)
    else $error("forced bad parity not detected on read");

  nmi_hold_a: assert property (
    ram_parity_flag_o && !status_write_i |=> ram_parity_flag_o[*2] or status_write_i)
    else $error("parity status dropped without a status write");

endmodule

// ===== verification/cpu_bus_model.sv
// Purpose: Processor model that runs logical bus cycles against the block.
// Assumes: One cycle at a time; answers are sampled at rising edges.
// Notes: Released address and data lines show the inverse of the last value.
`timescale 1ns/100ps
module cpu_bus_model
  import irq_pkg::*;
(
  input wire logic clock_i,
  input wire logic dsack_i,
  input wire logic autovec_i,
  input wire logic berr_i,
  input wire logic mmu_sel_i,
  input wire logic fpu_sel_i,
  input wire logic [VEC_W-1:0] rdata_i,
  output logic as_b_o,
  output logic rw_o,
  output logic [2:0] fc_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [VEC_W-1:0] data_o
);
  // The strobe idles high until a cycle is asked for.
  initial begin
    as_b_o = 1'b1;
    rw_o = 1'b1;
    fc_o = 3'h0;
    addr_o = '0;
    data_o = 8'h00;
  end

  // Holds the cycle until an answer or four edges; an unclaimed cycle returns response zero,
  // since the real processor would only end it by its own timeout.
  task automatic run(input logic [2:0] f, input logic [ADDR_W-1:0] a, input logic r,
                     input logic [VEC_W-1:0] d, output logic [VEC_W-1:0] q,
                     output logic [2:0] resp, output logic [1:0] sel);
    @(posedge clock_i);
    fc_o <= f;
    addr_o <= a;
    rw_o <= r;
    data_o <= d;
    as_b_o <= 1'b0;
    resp = 3'h0;
    q = 8'h00;
    @(posedge clock_i);
    #1;
    sel = {fpu_sel_i, mmu_sel_i};
    for (int n = 0; n < 4 && resp == 3'h0; n++) begin
      @(posedge clock_i);
      resp = {berr_i, autovec_i, dsack_i};
      q = rdata_i;
    end
    as_b_o <= 1'b1;
    addr_o <= ~a;
    data_o <= ~d;
    @(posedge clock_i);
  endtask
endmodule

// ===== verification/irq_vector_and_parity_nmi_bench.sv
// Purpose: Self-checking bench for vectoring, level 7 and parity memory.
// Assumes: Default parameters; the processor model drives the logical bus.
// Notes: Pins pass a synchroniser, so eight cycles are waited after a pin change.
`timescale 1ns/100ps
module irq_vector_and_parity_nmi_bench;
  import irq_pkg::*;

  localparam int SETTLE = 8;
  localparam int LIMIT = 20000;

  logic clock_i, rst_b_i, as_b, rw, dsack, autovec, berr, mmu_sel, fpu_sel;
  logic [2:0] fc, ipl;
  logic [ADDR_W-1:0] addr;
  logic [VEC_W-1:0] wdata, rdata;
  logic [REQ_LINES-1:0] request;
  logic chk_n, status_wr, ram_flag, io_flag, diag, mem_wr, mem_rd, rvalid, perr;
  logic [MEM_AW_DEF-1:0] mem_addr;
  logic [DATA_W-1:0] mem_wdata, mem_rdata;
  logic [DATA_W:0] mem_model[$];
  int mismatches, cmp_count;
  int cycles = 0;

  irq_vector_parity_nmi dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .as_b_i(as_b), .rw_i(rw),
    .fc_i(fc), .addr_i(addr), .data_i(wdata), .data_o(rdata), .dsack_o(dsack),
    .autovec_o(autovec), .berr_o(berr), .mmu_sel_o(mmu_sel), .fpu_sel_o(fpu_sel),
    .ipl_o(ipl), .request_i(request), .io_channel_check_n_i(chk_n),
    .status_write_i(status_wr), .ram_parity_flag_o(ram_flag), .io_check_flag_o(io_flag),
    .diag_bad_parity_i(diag), .mem_addr_i(mem_addr), .mem_wr_i(mem_wr), .mem_rd_i(mem_rd),
    .mem_wdata_i(mem_wdata), .mem_rdata_o(mem_rdata), .mem_rvalid_o(rvalid),
    .parity_error_o(perr));

  cpu_bus_model cpu (.clock_i(clock_i), .dsack_i(dsack), .autovec_i(autovec), .berr_i(berr),
    .mmu_sel_i(mmu_sel), .fpu_sel_i(fpu_sel), .rdata_i(rdata), .as_b_o(as_b), .rw_o(rw),
    .fc_o(fc), .addr_o(addr), .data_o(wdata));

  // Free-running 100 MHz clock.
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // Compares one value and counts it.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  function automatic logic [ADDR_W-1:0] iack(input logic [2:0] lvl);
    logic [ADDR_W-1:0] a;
    a = '0;
    a[CPU_TYPE_HI:CPU_TYPE_LO] = CPU_TYPE_IACK;
    a[IACK_LVL_HI:IACK_LVL_LO] = lvl;
    return a;
  endfunction

  function automatic logic [2:0] lowest(input logic [7:0] v);
    logic [2:0] k;
    k = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) k = i[2:0];
    end
    return k;
  endfunction

  // Controller 2 answers only when controller 1 picks its cascade input.
  function automatic logic [7:0] exp_vec(input logic [15:0] rq, input logic [4:0] b1, b2);
    logic [7:0] c1;
    c1 = rq[7:0];
    c1[CASCADE_INPUT] = c1[CASCADE_INPUT] | (|rq[15:8]);
    if (lowest(c1) == CASCADE_INPUT && |rq[15:8]) return {b2, lowest(rq[15:8])};
    return {b1, lowest(c1)};
  endfunction

  task automatic clear_status();
    @(posedge clock_i);
    status_wr <= 1'b1;
    @(posedge clock_i);
    status_wr <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask

  task automatic mem_write(input int a, input logic [31:0] d, input logic bad);
    @(posedge clock_i);
    mem_addr <= a[MEM_AW_DEF-1:0];
    mem_wdata <= d;
    diag <= bad;
    mem_wr <= 1'b1;
    @(posedge clock_i);
    mem_wr <= 1'b0;
    diag <= 1'b0;
  endtask

  // Reads one word against the model; now skips the wait so the read lands on the edge
  // right after a write, which is the only way to reach the write-then-reread checks.
  task automatic mem_read(input int a, input logic now);
    if (!now) begin
      @(posedge clock_i);
    end
    mem_addr <= a[MEM_AW_DEF-1:0];
    mem_rd <= 1'b1;
    @(posedge clock_i);
    mem_rd <= 1'b0;
    #1;
    check(rvalid, 1'b1);
    check(mem_rdata, mem_model[a][31:0]);
    check(perr, mem_model[a][32]);
  endtask

  // A hang counts as a mismatch and goes to the closing report.
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      wrap_up();
    end
  end

  initial begin
    logic [7:0] q;
    logic [2:0] r;
    logic [1:0] s;
    logic [4:0] b1, b2;
    logic [15:0] rq;
    logic bad;
    rst_b_i = 1'b0;
    request = '0;
    chk_n = 1'b1;
    status_wr = 1'b0;
    diag = 1'b0;
    mem_wr = 1'b0;
    mem_rd = 1'b0;
    mem_addr = '0;
    mem_wdata = '0;
    mismatches = 0;
    cmp_count = 0;
    void'($urandom(32'h0000_f7e1));
    repeat (16) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    check({ipl, ram_flag, io_flag, dsack, autovec, berr}, 8'h00);
    cpu.run(FC_CPU_SPACE, 24'h01_0000, 1'b1, 8'h00, q, r, s);
    check(s, 2'b01);
    cpu.run(FC_CPU_SPACE, 24'h02_2000, 1'b1, 8'h00, q, r, s);
    check(s, 2'b10);
    $display("Test reset and decode done");
    // Load both vector bases, then walk every input and some random mixes.
    b1 = 5'($urandom);
    b2 = 5'($urandom);
    cpu.run(3'h1, CTRL1_ADDR, 1'b0, {b1, 3'h0}, q, r, s);
    check(r, 3'h1);
    cpu.run(3'h1, CTRL2_ADDR, 1'b0, {b2, 3'h0}, q, r, s);
    for (int i = 0; i < 24; i++) begin
      rq = (i < 16) ? (16'h0001 << i) : (16'($urandom) & 16'($urandom) & 16'($urandom));
      if (i == 21) rq = 16'h0000;
      @(posedge clock_i);
      request <= rq;
      repeat (SETTLE) @(posedge clock_i);
      check(ipl, (rq != 0) ? CTRL_LEVEL_DEF : IPL_NONE);
      cpu.run(FC_CPU_SPACE, iack(CTRL_LEVEL_DEF), 1'b1, 8'h00, q, r, s);
      check(r, (rq != 0) ? 3'h1 : 3'h4);
      if (rq != 0) check(q, exp_vec(rq, b1, b2));
      cpu.run(3'h1, CTRL2_ADDR, 1'b1, 8'h00, q, r, s);
      check(q, rq[15:8]);
      cpu.run(3'h1, CTRL1_ADDR, 1'b1, 8'h00, q, r, s);
      check(q, {rq[7:3], rq[2] | (|rq[15:8]), rq[1:0]});
    end
    request <= '0;
    $display("Test vectoring done");
    // Words written with forced bad parity must fail on read; the last two, one clean
    // and one forced bad, are also read back on the edge right after their write.
    for (int a = 0; a < 16; a++) begin
      bad = (a == 5) || (a == 15) || (a < 14 && $urandom % 8 == 0);
      mem_model.push_back({bad, 32'($urandom)});
      mem_write(a, mem_model[a][31:0], bad);
      if (a >= 14) begin
        mem_read(a, 1'b1);
      end
    end
    for (int a = 15; a >= 0; a--) begin
      mem_read(a, 1'b0);
    end
    repeat (2) @(posedge clock_i);
    check({ram_flag, io_flag}, 2'b10);
    request <= 16'h0001;
    repeat (SETTLE) @(posedge clock_i);
    check(ipl, NMI_LEVEL);
    cpu.run(FC_CPU_SPACE, iack(NMI_LEVEL), 1'b1, 8'h00, q, r, s);
    check(r, 3'h2);
    check(ram_flag, 1'b1);
    clear_status();
    check({ram_flag, io_flag}, 2'b00);
    check(ipl, CTRL_LEVEL_DEF);
    cpu.run(FC_CPU_SPACE, iack(NMI_LEVEL), 1'b1, 8'h00, q, r, s);
    check(r, 3'h4);
    request <= '0;
    $display("Test parity done");
    // Channel check held low survives a clear; released, it stays latched.
    chk_n <= 1'b0;
    repeat (SETTLE) @(posedge clock_i);
    check({ram_flag, io_flag}, 2'b01);
    check(ipl, NMI_LEVEL);
    clear_status();
    check(io_flag, 1'b1);
    chk_n <= 1'b1;
    repeat (SETTLE) @(posedge clock_i);
    check(io_flag, 1'b1);
    cpu.run(FC_CPU_SPACE, iack(NMI_LEVEL), 1'b1, 8'h00, q, r, s);
    check(r, 3'h2);
    clear_status();
    check({ipl, io_flag}, 4'h0);
    cpu.run(3'h1, CTRL1_ADDR + 24'h00_0200, 1'b0, 8'hff, q, r, s);
    check(r, 3'h0);
    $display("Test channel check done");
    wrap_up();
  end
endmodule
